// File: design/nand_host_map.svh
// Register offsets, command codes and timing counts of the NAND host
`ifndef NAND_HOST_MAP_SVH
`define NAND_HOST_MAP_SVH

`define OFS_CTRL    8'h00
`define OFS_STATUS  8'h04
`define OFS_SRC     8'h08
`define OFS_DEST    8'h0c
`define OFS_LEN     8'h10
`define OFS_MASK    8'h14
`define OFS_BUF     8'h18

`define CTRL_GO_BIT    8
`define STAT_ERR_BIT   1
`define ARRAY_READY_STATUS_BIT 5
`define MASK_RESET     8'h40

`define CMD_READ       8'h00
`define CMD_PROG_DIN   8'h80
`define CMD_COPY_DIN   8'h85
`define CMD_CONFIRM    8'h10
`define CMD_CACHE      8'h15
`define CMD_COPY_READ  8'h35
`define CMD_ERASE      8'h60
`define CMD_ERASE_GO   8'hd0
`define CMD_STATUS     8'h70

`define PAGE_BYTES     2112
`define BUF_AW         12

`define CLK_PERIOD_NS  25
`define WE_LOW_NS      60
`define WE_HIGH_NS     20
`define RE_LOW_NS      150
`define RE_HIGH_NS     20
`define BUSY_WAIT_NS   100
`define CYC_MIN(ns) (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WE_LOW_CYC   `CYC_MIN(`WE_LOW_NS)
`define WE_HIGH_CYC  `CYC_MIN(`WE_HIGH_NS)
`define RE_LOW_CYC   `CYC_MIN(`RE_LOW_NS)
`define RE_HIGH_CYC  `CYC_MIN(`RE_HIGH_NS)
`define BUSY_WAIT_CYC `CYC_MIN(`BUSY_WAIT_NS)

`endif

// File: design/nand_host_pkg.sv
// Types shared by the NAND host sequencer and its page buffer
`default_nettype none
package nand_host_pkg;

  typedef enum logic [2:0] {
    OP_PROG   = 3'h0,
    OP_CACHE  = 3'h1,
    OP_COPY   = 3'h2,
    OP_ERASE  = 3'h3,
    OP_POLL   = 3'h4,
    OP_RESUME = 3'h5
  } op_t;

  typedef enum logic [2:0] {
    K_CMD, K_ADR, K_DIN, K_DOUT, K_WAIT, K_SKIP, K_END
  } kind_t;

  typedef struct packed {
    kind_t      kind;
    logic [7:0] val;
  } cycle_t;

  typedef enum logic [2:0] {S_IDLE, S_STEP, S_LOW, S_HIGH, S_WAIT} seq_state_t;

  typedef struct packed {
    logic       ce_n;
    logic       cle;
    logic       ale;
    logic       we_n;
    logic       output_strobe_n;
    logic [7:0] io_out;
    logic       io_oe;
  } pin_out_t;

  typedef struct packed {
    logic [11:0] waddr;
    logic [7:0]  wdata;
    logic        we;
    logic [11:0] raddr;
  } buf_req_t;

endpackage
`default_nettype wire

// File: design/page_buf.sv
// Page data buffer with registered read port
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_map.svh"
module page_buf (
  // Clock
  input  wire logic                  hclk,
  // Access
  input  wire nand_host_pkg::buf_req_t req,
  output logic [7:0]                 rdata
);

  logic [7:0] mem [0:`PAGE_BYTES-1];

  // Storage needs no reset; read data is a plain register
  always_ff @(posedge hclk) begin
    if (req.we) begin
      mem[req.waddr] <= req.wdata;
    end
    rdata <= mem[req.raddr];
  end

endmodule // page_buf
`default_nettype wire

// File: design/nand_host_seq.sv
// NAND host sequencer: program, cache program, copy-back, erase, status
//
// The address map and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_map.svh"
// Function
// R1 - Page buffer holds 2112 bytes; cache chains stay within one block.
// R2 - Device frees cache and starts programming on confirm 15h.
// R3 - Device stays briefly busy, then accepts new data while programming.
// R4 - Device reports cache readiness on status bit 6 after 70h.
// R5 - Device lengthens cache busy until pending programming ends.
// R6 - Device reports true array readiness on status bit 5.
// R7 - Last page confirmed with 10h when completion tracked by ready pin.
// R8 - After last 15h, poll array ready bit before any other operation. Code refuses only copy-back, erase and resume; program is not blocked.
// R9 - Device gives previous page result on bit 1, current on bit 0.
// R10 - Device reads source page internally on 35h without output.
// R11 - After ready, write 85h with destination address, then 10h.
// R12 - Data cycles may overwrite portions of the buffered page before confirm.
// R13 - Device flags copy-back program failure in pass/fail bit.
// R14 - Copy-back repetition should be covered by two-bit error correction.
// R15 - Erase begins with 60h and exactly two row address cycles.
// R16 - Device uses only block bits of the erase row address.
// R17 - Device starts erase on the rising write strobe of D0h.
// R18 - Device gives erase result on status bit 0.
// R19 - Device drives status on later falling chip select or read strobe.
// R20 - Device status follows live state without strobe toggling.
// R21 - Device stays in status mode until another command.
// R22 - After status read mid random read, reissue 00h before data reads.
// R23 - Device true ready bit follows array programming in cache mode.
// R24 - Mask status bits unused by the current operation.
// R25 - Device status: pass 0, fail 1; busy 0, ready 1.
module nand_host_seq (
  // Clock and reset
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  // AHB-Lite slave
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic [31:0]            hwdata,
  input  wire logic                   hready,
  output logic                        hreadyout,
  output logic                        hresp,
  output logic [31:0]                 hrdata,
  // Flash pins
  output var  nand_host_pkg::pin_out_t pins,
  input  wire logic [7:0]             io_in,
  input  wire logic                   ready_busy
);

  typedef struct packed {
    nand_host_pkg::seq_state_t st;
    nand_host_pkg::op_t        op;
    logic [4:0]                step;
    logic [11:0]               cnt;
    logic [3:0]                tim;
    logic                      rb_s1;
    logic                      rb_s2;
    logic [7:0]                io_s1;
    logic [7:0]                io_s2;
    nand_host_pkg::pin_out_t   p;
    logic                      wr_pend;
    logic [7:0]                waddr;
    logic [31:0]               rdata_bus;
    logic [31:0]               src;
    logic [31:0]               dest;
    logic [11:0]               len;
    logic [7:0]                mask;
    logic [7:0]                nstat;
    logic [7:0]                rbyte;
    logic                      status_mode;
    logic                      chain_active;
    logic [9:0]                chain_blk;
    logic                      need_true_ready;
    logic                      err;
    logic [7:0]                copy_gen;
    logic [11:0]               wptr;
  } host_state_t;

  host_state_t               s_reg;
  host_state_t               s_next;
  nand_host_pkg::cycle_t     cyc;
  nand_host_pkg::buf_req_t   breq;
  logic [7:0]                buf_rdata;
  logic                      busy;

  page_buf u_buf (
    .hclk  (hclk),
    .req   (breq),
    .rdata (buf_rdata)
  );

  function automatic nand_host_pkg::cycle_t mk(nand_host_pkg::kind_t k,
                                               logic [7:0] v);
    nand_host_pkg::cycle_t c;
    c.kind = k;
    c.val  = v;
    return c;
  endfunction

  // Cycle list of each operation, indexed by step
  function automatic nand_host_pkg::cycle_t step_cycle(host_state_t s);
    nand_host_pkg::cycle_t c;
    c = mk(nand_host_pkg::K_END, 8'h00);
    unique case (s.op)
      nand_host_pkg::OP_PROG, nand_host_pkg::OP_CACHE: begin
        if (s.step == 5'h00) c = mk(nand_host_pkg::K_CMD, `CMD_PROG_DIN);
        else if (s.step <= 5'h04) c = mk(nand_host_pkg::K_ADR,
                                    s.src[8*(s.step-5'h01) +: 8]);
        else if (s.step == 5'h05) c = mk(nand_host_pkg::K_DIN, 8'h00);
        // R7 last page uses 10h
        else if (s.step == 5'h06) c = mk(nand_host_pkg::K_CMD,
            (s.op == nand_host_pkg::OP_CACHE) ? `CMD_CACHE : `CMD_CONFIRM);
        else if (s.step == 5'h07) c = mk(nand_host_pkg::K_WAIT, 8'h00);
      end
      nand_host_pkg::OP_COPY: begin
        if (s.step == 5'h00) c = mk(nand_host_pkg::K_CMD, `CMD_READ);
        else if (s.step <= 5'h04) c = mk(nand_host_pkg::K_ADR,
                                    s.src[8*(s.step-5'h01) +: 8]);
        else if (s.step == 5'h05) c = mk(nand_host_pkg::K_CMD, `CMD_COPY_READ);
        else if (s.step == 5'h06) c = mk(nand_host_pkg::K_WAIT, 8'h00);
        // R11 destination after ready
        else if (s.step == 5'h07) c = mk(nand_host_pkg::K_CMD, `CMD_COPY_DIN);
        else if (s.step <= 5'h0b) c = mk(nand_host_pkg::K_ADR,
                                    s.dest[8*(s.step-5'h08) +: 8]);
        // R12 optional overwrite data
        else if (s.step == 5'h0c) c = mk(nand_host_pkg::K_DIN, 8'h00);
        else if (s.step == 5'h0d) c = mk(nand_host_pkg::K_CMD, `CMD_CONFIRM);
        else if (s.step == 5'h0e) c = mk(nand_host_pkg::K_WAIT, 8'h00);
      end
      nand_host_pkg::OP_ERASE: begin
        // R15 setup and two row cycles
        if (s.step == 5'h00) c = mk(nand_host_pkg::K_CMD, `CMD_ERASE);
        else if (s.step <= 5'h02) c = mk(nand_host_pkg::K_ADR,
                                    s.src[8*(s.step+5'h01) +: 8]);
        else if (s.step == 5'h03) c = mk(nand_host_pkg::K_CMD, `CMD_ERASE_GO);
        else if (s.step == 5'h04) c = mk(nand_host_pkg::K_WAIT, 8'h00);
      end
      nand_host_pkg::OP_POLL: begin
        if (s.step == 5'h00) c = mk(nand_host_pkg::K_CMD, `CMD_STATUS);
        else if (s.step == 5'h01) c = mk(nand_host_pkg::K_DOUT, 8'h00);
      end
      nand_host_pkg::OP_RESUME: begin
        // R22 leave status mode first
        if (s.step == 5'h00) c = s.status_mode ?
            mk(nand_host_pkg::K_CMD, `CMD_READ) : mk(nand_host_pkg::K_SKIP, 8'h00);
        else if (s.step == 5'h01) c = mk(nand_host_pkg::K_DOUT, 8'h00);
      end
      default: c = mk(nand_host_pkg::K_END, 8'h00);
    endcase
    return c;
  endfunction

  assign cyc       = step_cycle(s_reg);
  assign busy      = (s_reg.st != nand_host_pkg::S_IDLE);
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = s_reg.rdata_bus;
  assign pins      = s_reg.p;

  always_comb begin
    logic       go;
    logic       wr_ok;
    logic [2:0] op_code;
    go      = 1'b0;
    wr_ok   = 1'b0;
    op_code = 3'h0;
    s_next  = s_reg;
    // Pins pass two flops before anything reads them
    s_next.rb_s1 = ready_busy;
    s_next.rb_s2 = s_reg.rb_s1;
    s_next.io_s1 = io_in;
    s_next.io_s2 = s_reg.io_s1;
    breq.we    = 1'b0;
    breq.waddr = s_reg.wptr;
    breq.wdata = hwdata[7:0];

    // Register bus: address phase, then data phase for writes
    s_next.wr_pend = 1'b0;
    if (hsel && htrans[1] && hready) begin
      s_next.wr_pend = hwrite;
      s_next.waddr   = haddr[7:0];
      s_next.rdata_bus = 32'h0000_0000;
      if (!hwrite) begin
        unique case (haddr[7:0])
          `OFS_STATUS: s_next.rdata_bus = {s_reg.copy_gen, s_reg.rbyte,
              s_reg.nstat, 3'h0, s_reg.rb_s2, s_reg.need_true_ready,
              s_reg.chain_active, s_reg.err, busy};
          `OFS_SRC:  s_next.rdata_bus = s_reg.src;
          `OFS_DEST: s_next.rdata_bus = s_reg.dest;
          `OFS_LEN:  s_next.rdata_bus = {20'h0_0000, s_reg.len};
          `OFS_MASK: s_next.rdata_bus = {24'h00_0000, s_reg.mask};
          default:   s_next.rdata_bus = 32'h0000_0000;
        endcase
      end
    end
    if (s_reg.wr_pend) begin
      unique case (s_reg.waddr)
        `OFS_CTRL: begin
          go      = hwdata[`CTRL_GO_BIT];
          op_code = hwdata[2:0];
        end
        `OFS_STATUS: if (hwdata[`STAT_ERR_BIT]) s_next.err = 1'b0;
        `OFS_SRC:  s_next.src  = hwdata;
        `OFS_DEST: s_next.dest = hwdata;
        `OFS_LEN: begin
          // R1 buffer never exceeds one page
          s_next.len  = (hwdata[11:0] > 12'(`PAGE_BYTES)) ?
                        12'(`PAGE_BYTES) : hwdata[11:0];
          s_next.wptr = 12'h000;
        end
        `OFS_MASK: s_next.mask = hwdata[7:0];
        `OFS_BUF: begin
          breq.we = (s_reg.wptr < 12'(`PAGE_BYTES));
          if (breq.we) s_next.wptr = s_reg.wptr + 12'h001;
        end
        default: ;
      endcase
    end

    // Start of an operation; starts refused by the chain or true-ready checks set the sticky error
    if (go && !busy && op_code <= 3'h5) begin
      wr_ok = 1'b1;
      unique case (nand_host_pkg::op_t'(op_code))
        // R1 cache chain within one block
        nand_host_pkg::OP_CACHE:
          wr_ok = !(s_reg.chain_active &&
                    s_reg.chain_blk != s_reg.src[31:22]);
        // R8 true ready before copy-back, erase or resume
        nand_host_pkg::OP_COPY, nand_host_pkg::OP_ERASE,
        nand_host_pkg::OP_RESUME: wr_ok = !s_reg.need_true_ready;
        default: ;
      endcase
      if (!wr_ok) s_next.err = 1'b1;
    end
    if (wr_ok) begin
      s_next.op   = nand_host_pkg::op_t'(op_code);
      s_next.st   = nand_host_pkg::S_STEP;
      s_next.step = 5'h00;
      s_next.cnt  = 12'h000;
      s_next.p.ce_n = 1'b0;
      if (s_next.op == nand_host_pkg::OP_CACHE) begin
        s_next.chain_active    = 1'b1;
        s_next.chain_blk       = s_reg.src[31:22];
        s_next.need_true_ready = 1'b1;
      end
      if (s_next.op == nand_host_pkg::OP_PROG ||
          s_next.op == nand_host_pkg::OP_CACHE) s_next.copy_gen = 8'h00;
      // R14 count copy-back generations for ECC policy
      if (s_next.op == nand_host_pkg::OP_COPY)
        s_next.copy_gen = s_reg.copy_gen + 8'h01;
    end

    unique case (s_reg.st)
      nand_host_pkg::S_IDLE: s_next.p.ce_n = !wr_ok;
      nand_host_pkg::S_STEP: begin
        if (cyc.kind == nand_host_pkg::K_END) begin
          s_next.st     = nand_host_pkg::S_IDLE;
          s_next.p.ce_n = 1'b1;
          if (s_reg.op == nand_host_pkg::OP_PROG) begin
            s_next.chain_active    = 1'b0;
            s_next.need_true_ready = 1'b0;
          end
        end else if (cyc.kind == nand_host_pkg::K_SKIP ||
                     (cyc.kind == nand_host_pkg::K_DIN &&
                      s_reg.len == 12'h000)) begin
          s_next.step = s_reg.step + 5'h01;
        end else if (cyc.kind == nand_host_pkg::K_WAIT) begin
          s_next.tim = 4'(`BUSY_WAIT_CYC - 1);
          s_next.st  = nand_host_pkg::S_WAIT;
        end else if (cyc.kind == nand_host_pkg::K_DOUT) begin
          s_next.p.output_strobe_n = 1'b0;
          s_next.tim = 4'(`RE_LOW_CYC - 1);
          s_next.st  = nand_host_pkg::S_LOW;
        end else begin
          s_next.p.cle    = (cyc.kind == nand_host_pkg::K_CMD);
          s_next.p.ale    = (cyc.kind == nand_host_pkg::K_ADR);
          s_next.p.io_out = (cyc.kind == nand_host_pkg::K_DIN) ?
                            buf_rdata : cyc.val;
          s_next.p.io_oe  = 1'b1;
          s_next.p.we_n   = 1'b0;
          s_next.tim = 4'(`WE_LOW_CYC - 1);
          s_next.st  = nand_host_pkg::S_LOW;
          if (cyc.kind == nand_host_pkg::K_CMD)
            s_next.status_mode = (cyc.val == `CMD_STATUS);
        end
      end
      nand_host_pkg::S_LOW: begin
        if (s_reg.tim != 4'h0) begin
          s_next.tim = s_reg.tim - 4'h1;
        end else if (!s_reg.p.output_strobe_n) begin
          if (s_reg.op == nand_host_pkg::OP_POLL) s_next.nstat = s_reg.io_s2;
          else s_next.rbyte = s_reg.io_s2;
          s_next.p.output_strobe_n = 1'b1;
          s_next.tim = 4'(`RE_HIGH_CYC - 1);
          s_next.st  = nand_host_pkg::S_HIGH;
        end else begin
          s_next.p.we_n = 1'b1;
          s_next.tim = 4'(`WE_HIGH_CYC - 1);
          s_next.st  = nand_host_pkg::S_HIGH;
        end
      end
      nand_host_pkg::S_HIGH: begin
        if (s_reg.tim != 4'h0) begin
          s_next.tim = s_reg.tim - 4'h1;
        end else begin
          s_next.p.cle   = 1'b0;
          s_next.p.ale   = 1'b0;
          s_next.p.io_oe = 1'b0;
          s_next.st      = nand_host_pkg::S_STEP;
          if (cyc.kind == nand_host_pkg::K_DIN &&
              s_reg.cnt + 12'h001 < s_reg.len) begin
            s_next.cnt = s_reg.cnt + 12'h001;
          end else if (cyc.kind == nand_host_pkg::K_DOUT &&
                       s_reg.op == nand_host_pkg::OP_POLL &&
                       // R24 only unmasked bits decide
                       (s_reg.nstat & s_reg.mask) != s_reg.mask) begin
            s_next.step = s_reg.step;
          end else begin
            s_next.step = s_reg.step + 5'h01;
            s_next.cnt  = 12'h000;
          end
          // R8 array ready bit ends the chain
          if (s_reg.op == nand_host_pkg::OP_POLL &&
              cyc.kind == nand_host_pkg::K_DOUT &&
              s_reg.nstat[`ARRAY_READY_STATUS_BIT]) begin
            s_next.need_true_ready = 1'b0;
            s_next.chain_active    = 1'b0;
          end
        end
      end
      nand_host_pkg::S_WAIT: begin
        if (s_reg.tim != 4'h0) s_next.tim = s_reg.tim - 4'h1;
        else if (s_reg.rb_s2) begin
          s_next.st   = nand_host_pkg::S_STEP;
          s_next.step = s_reg.step + 5'h01;
        end
      end
    endcase
    // Buffer read address leads by one cycle so data meets the strobe
    breq.raddr = s_next.cnt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_reg        <= '0;
      s_reg.st     <= nand_host_pkg::S_IDLE;
      s_reg.p.ce_n <= 1'b1;
      s_reg.p.we_n <= 1'b1;
      s_reg.p.output_strobe_n <= 1'b1;
      s_reg.mask   <= `MASK_RESET;
    end else begin
      s_reg <= s_next;
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_WE_WIDTH: assert property ($fell(s_reg.p.we_n) |-> // R11
    !s_reg.p.we_n [*3] ##1 s_reg.p.we_n)
    else $error("write strobe low width wrong");
  AST_IDLE_DESELECT: assert property (!busy |=> s_reg.p.ce_n || busy) // R11
    else $error("chip select low while idle");
  AST_ERASE_ROWS: assert property ($fell(s_reg.p.we_n) && // R15
    s_reg.op == nand_host_pkg::OP_ERASE && s_reg.step != 5'h00 &&
    s_reg.step != 5'h03 |-> s_reg.p.ale && !s_reg.p.cle)
    else $error("erase address cycle not latched as address");
  AST_LAST_CONFIRM: assert property ($fell(s_reg.p.we_n) && // R7
    s_reg.op == nand_host_pkg::OP_PROG && s_reg.step == 5'h06
    |-> s_reg.p.io_out == 8'h10 && s_reg.p.cle)
    else $error("last page not confirmed with 10h");
  AST_CHAIN_BLOCK: assert property (!busy && s_reg.chain_active && // R1
    s_next.op == nand_host_pkg::OP_CACHE && s_next.st == nand_host_pkg::S_STEP
    |-> s_reg.chain_blk == s_reg.src[31:22])
    else $error("cache chain crossed a block");
  AST_TRUE_READY: assert property ($rose(busy) && // R8
    s_reg.op inside {nand_host_pkg::OP_COPY, nand_host_pkg::OP_ERASE,
                     nand_host_pkg::OP_RESUME} |-> !$past(s_reg.need_true_ready))
    else $error("operation started before array ready");
  AST_RESUME_READ: assert property ($fell(s_reg.p.we_n) && // R22
    s_reg.op == nand_host_pkg::OP_RESUME |-> s_reg.p.io_out == 8'h00
    ##[1:12] !s_reg.p.output_strobe_n)
    else $error("resume did not issue 00h before data read");
  AST_POLL_EXIT: assert property (s_reg.op == nand_host_pkg::OP_POLL && // R24
    s_reg.st == nand_host_pkg::S_STEP && s_reg.step == 5'h02
    |-> (s_reg.nstat & s_reg.mask) == s_reg.mask)
    else $error("poll ended with masked bits not set");
  AST_COPY_DEST: assert property ($fell(s_reg.p.we_n) && // R11
    s_reg.op == nand_host_pkg::OP_COPY && s_reg.step == 5'h07
    |-> s_reg.p.io_out == 8'h85 && $past(s_reg.rb_s2, 2))
    else $error("copy destination written before ready");
  AST_READ_DRIVE: assert property (!s_reg.p.output_strobe_n |-> // R12
    !s_reg.p.io_oe && s_reg.p.we_n)
    else $error("host drives data lines during read strobe");

endmodule // nand_host_seq
`default_nettype wire

// File: bench/nand_dev_model.sv
// Behavioural NAND device facing the host sequencer
`timescale 1ns/1ps
`default_nettype none
module nand_dev_model (
  // Clock for busy timing
  input  wire logic                    hclk,
  // Flash pins
  input  wire nand_host_pkg::pin_out_t pins,
  input  wire logic                    fail_next,
  output logic [7:0]                   io_in,
  output logic                         ready_busy
);
  logic [7:0] cmd_log[$];
  logic [7:0] adr_log[$];
  logic [7:0] din_log[$];
  logic [9:0] erased_blk;
  logic       stat_mode, pf_cur, pf_prev;
  int         cache_left, array_left;
  wire        we_n = pins.we_n;
  wire  [7:0] status = {1'b1, cache_left == 0, array_left == 0, 3'h0,
                        pf_prev, pf_cur};
  initial begin
    {stat_mode, pf_cur, pf_prev, erased_blk} = '0;
    {cache_left, array_left} = '0;
    io_in = 8'h00;
    ready_busy = 1'b1;
  end
  always @(posedge we_n) begin
    if (!pins.ce_n && pins.cle) begin
      cmd_log.push_back(pins.io_out);
      // status mode held until next command
      stat_mode = (pins.io_out == 8'h70);
      case (pins.io_out)
        // cache transfer waits for the pending program
        8'h15: begin
          cache_left = array_left + 4;
          array_left = cache_left + 40;
          pf_prev = pf_cur;
          pf_cur = fail_next;
        end
        // program or erase, result on bit 0
        8'h10, 8'hd0: begin
          array_left = array_left + 40;
          cache_left = array_left;
          pf_prev = pf_cur;
          pf_cur = fail_next;
        end
        // internal page read, nothing driven out
        8'h35: begin
          cache_left = 20;
          array_left = 20;
        end
        default: ;
      endcase
      // page bits below the block field ignored
      if (pins.io_out == 8'hd0) erased_blk = {adr_log[1], adr_log[0][7:6]};
    end else if (!pins.ce_n && pins.ale) adr_log.push_back(pins.io_out);
    // data cycles overwrite the buffered page
    else if (!pins.ce_n) din_log.push_back(pins.io_out);
  end
  // live status while select and strobe are both low
  always @(posedge hclk) begin
    if (cache_left > 0) cache_left--;
    if (array_left > 0) array_left--;
    // Released lines must not hold the last value
    if (stat_mode && !pins.ce_n && !pins.output_strobe_n) io_in <= status;
    else io_in <= ~io_in;
    ready_busy <= (cache_left == 0);
  end
endmodule // nand_dev_model
`default_nettype wire

// File: bench/tb_nand_host_seq.sv
// Self-checking bench for the NAND host sequencer
`timescale 1ns/1ps
`default_nettype none
`include "nand_host_map.svh"
module tb_nand_host_seq;
  logic                    hclk, hresetn, hsel, hwrite, fail_next;
  logic                    hreadyout, hresp, ready_busy;
  logic [1:0]              htrans;
  logic [2:0]              hsize;
  logic [31:0]             haddr, hwdata, hrdata, rd;
  logic [7:0]              io_in;
  nand_host_pkg::pin_out_t pins;
  int                      fail_count, check_count;
  nand_host_seq dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .pins(pins), .io_in(io_in),
    .ready_busy(ready_busy));
  nand_dev_model dev (.hclk(hclk), .pins(pins), .fail_next(fail_next),
    .io_in(io_in), .ready_busy(ready_busy));
  always #12.5 hclk = ~hclk;
  task check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wr, 24'h0, a};
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask
  task stat;
    bus(1'b0, `OFS_STATUS, 32'h0);
  endtask
  // Bounded wait on the busy flag
  task go(input logic [2:0] op);
    int n;
    dev.cmd_log.delete();
    dev.adr_log.delete();
    dev.din_log.delete();
    bus(1'b1, `OFS_CTRL, {23'h0, 1'b1, 5'h0, op});
    n = 0;
    stat;
    while (rd[0] !== 1'b0 && n < 3000) begin
      stat;
      n++;
    end
    check(rd[0], 1'b0);
  endtask
  task load(input logic [31:0] src, input int n);
    bus(1'b1, `OFS_SRC, src);
    bus(1'b1, `OFS_LEN, 32'(n));
    for (int i = 0; i < n; i++) bus(1'b1, `OFS_BUF, 32'h30 + i);
  endtask
  task t_regs;
    bus(1'b0, `OFS_MASK, 32'h0);
    check(rd, 32'h40);
    bus(1'b1, 8'h20, 32'hff);
    bus(1'b0, 8'h20, 32'h0);
    check(rd, 32'h0);
    check({30'h0, hreadyout, hresp}, 32'h2);
    $display("test regs done");
  endtask
  task t_prog;
    load(32'h0000_0a5c, 3);
    go(3'h0);
    check(dev.cmd_log.size(), 2);
    check(dev.cmd_log[1], 8'h10);
    check(dev.adr_log[0], 8'h5c);
    check(dev.din_log[2], 8'h32);
    $display("test prog done");
  endtask
  task t_cache;
    load(32'h0040_0000, 2);
    go(3'h1);
    stat;
    check(rd[3:2], 2'h3);
    load(32'h0040_0000, 2);
    go(3'h1);
    check(dev.cmd_log[1], 8'h15);
    load(32'h0080_0000, 1);
    go(3'h1);
    stat;
    check(rd[1], 1'b1);
    bus(1'b1, `OFS_STATUS, 32'h2);
    go(3'h3);
    stat;
    check(rd[1], 1'b1);
    bus(1'b1, `OFS_STATUS, 32'h2);
    bus(1'b1, `OFS_MASK, 32'h20);
    go(3'h4);
    stat;
    check(rd[3], 1'b0);
    check(rd[13], 1'b1);
    go(3'h5);
    check(dev.cmd_log[0], 8'h00);
    $display("test cache done");
  endtask
  task t_copy;
    logic [7:0] e[4];
    e = '{8'h00, 8'h35, 8'h85, 8'h10};
    fail_next <= 1'b1;
    bus(1'b1, `OFS_DEST, 32'h00c0_0012);
    load(32'h0100_0000, 1);
    go(3'h2);
    for (int i = 0; i < 4; i++) check(dev.cmd_log[i], e[i]);
    check(dev.adr_log[4], 8'h12);
    check(dev.din_log[0], 8'h30);
    bus(1'b1, `OFS_MASK, 32'h40);
    go(3'h4);
    stat;
    check(rd[8], 1'b1);
    check(rd[31:24], 8'h01);
    fail_next <= 1'b0;
    $display("test copy done");
  endtask
  task t_erase;
    bus(1'b1, `OFS_SRC, 32'hc3c0_4500);
    go(3'h3);
    check(dev.adr_log.size(), 2);
    check({dev.adr_log[1], dev.adr_log[0]}, 16'hc3c0);
    check({dev.cmd_log[0], dev.cmd_log[1]}, 16'h60d0);
    check(dev.erased_blk, 10'h30f);
    go(3'h5);
    check(dev.cmd_log.size(), 0);
    $display("test erase done");
  endtask
  initial begin
    {hclk, hresetn, hsel, hwrite, fail_next, htrans} = '0;
    {haddr, hwdata} = '0;
    hsize = 3'h2;
    fail_count = 0;
    check_count = 0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_prog;
    t_cache;
    t_copy;
    t_erase;
    wrap_up;
  end
  // Hang guard, far beyond the expected run length
  initial begin
    #2000000;
    fail_count++;
    wrap_up;
  end
endmodule // tb_nand_host_seq
`default_nettype wire
